// ---- pmrb_defs.svh ----
// constants for the management register bank
`ifndef PMRB_DEFS_SVH
`define PMRB_DEFS_SVH

`define PMRB_NREG        32
`define PMRB_CLK_NS      10
`define PMRB_RESET_NS    1200000
`define PMRB_TMR_W       20
`define PMRB_PRE_ONES    6'h20

`define PMRB_A_CTRL      5'h00
`define PMRB_A_STAT      5'h01
`define PMRB_A_IDH       5'h02
`define PMRB_A_IDL       5'h03
`define PMRB_A_ADV       5'h04
`define PMRB_A_LPA       5'h05
`define PMRB_A_EXP       5'h06
`define PMRB_A_NPT       5'h07
`define PMRB_A_SUMM      5'h10
`define PMRB_A_ICTL      5'h11
`define PMRB_A_ISTS      5'h12
`define PMRB_A_CNT0      5'h13
`define PMRB_A_CNT1      5'h14
`define PMRB_A_CNT2      5'h15
`define PMRB_A_PCS       5'h16
`define PMRB_A_LBK       5'h17
`define PMRB_A_TEN       5'h18
`define PMRB_A_DEVC      5'h19

`define PMRB_RW_MASK     32'h03FA_00F1

`define PMRB_B_SRST      15
`define PMRB_B_LOOP      14
`define PMRB_B_SPEED     13
`define PMRB_B_ANEN      12
`define PMRB_B_PDOWN     11
`define PMRB_B_DUPLEX    8
`define PMRB_B_ANDONE    5
`define PMRB_B_LINK      2
`define PMRB_B_IRQ_ANY   15

`define PMRB_STAT_PERM   16'h7809
`define PMRB_ADV_RST     16'h01E1
`define PMRB_ICTL_RST    16'h0000
`define PMRB_PCS_RST     16'h0000
`define PMRB_LBK_RST     16'h0000
`define PMRB_TEN_RST     16'h0000
`define PMRB_DEVC_RST    16'h0000

`endif

// ---- pmrb_pkg.sv ----
// types for the management register bank
`include "pmrb_defs.svh"

package pmrb_pkg;

  typedef enum logic [2:0] {
    PMRB_PRE   = 3'h0,
    PMRB_HDR   = 3'h1,
    PMRB_TA    = 3'h3,
    PMRB_RDATA = 3'h2,
    PMRB_WDATA = 3'h6
  } pmrb_mdio_e;

  typedef struct packed {
    logic disconnect;
    logic false_carrier;
    logic rx_error;
    logic neg_started;
    logic forced_mode;
  } pmrb_event_s;

  typedef struct packed {
    logic [3:0] d;
    logic       dv;
    logic       er;
  } pmrb_nib_s;

  typedef struct packed {
    logic speed_100;
    logic an_enable;
    logic full_duplex;
  } pmrb_strap_s;

  typedef struct packed {
    pmrb_mdio_e                      st;
    logic                            mdc_q;
    logic [5:0]                      cnt;
    logic [15:0]                     sh;
    logic                            op_rd;
    logic [4:0]                      reg_a;
    logic                            mdio_o;
    logic                            mdio_oe;
    logic [`PMRB_NREG-1:0][15:0]     rw;
    logic                            link_lat;
    logic [3:0]                      irq;
    logic                            busy;
    logic                            core_rst;
    logic                            start_seen;
    logic [`PMRB_TMR_W-1:0]          tmr;
    pmrb_strap_s                     strap;
    pmrb_nib_s                       rx;
  } pmrb_state_s;

endpackage : pmrb_pkg

// ---- pmrb_bank.sv ----
// management register bank reached over the serial management port
//
// Functional notes
// - read/write bits return the last written value, counters at 13h to 15h plus their events, and accept writes outside soft reset
// - read-only bits ignore writes and stay unchanged
// - latched status bits keep their event until the register is read
// - self-clearing bits drop to zero by themselves when their action ends
// - permanent bits always show their default value
// - writing one to control bit 15 starts a soft reset; defaults zero
// - soft reset returns every control and status register to defaults
// - reset bit reads one during the roughly 1.2 ms reset
// - reset completes once negotiation started or forced mode entered
// - control bit 14 loops transmit data back into the receive path
// - identifier registers sit at 02h and 03h, read-only
// - registers 04h to 07h are read/write
// - interrupt control at 11h read/write, interrupt status at 12h read-only
// - error counters at 13h, 14h, 15h are read/write
// - host reaches every register over the serial management port by address
`timescale 1ns/1ns
`default_nettype none
`include "pmrb_defs.svh"

module pmrb_bank #(
  parameter int unsigned         P_RESET_CYCLES =
    (`PMRB_RESET_NS + `PMRB_CLK_NS - 1) / `PMRB_CLK_NS,
  parameter logic [15:0]         P_ID_HIGH      = 16'h1234,  // arbitrary value
  parameter logic [15:0]         P_ID_LOW       = 16'h5670   // arbitrary value
) (
  // clock, reset, enable
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_clk_en,
  // serial management port
  input  wire logic                 i_mdc,
  input  wire logic                 i_mdio,
  output logic                      o_mdio,
  output logic                      o_mdio_oe,
  input  wire logic [4:0]           i_phy_addr,
  // straps and device state
  input  wire pmrb_pkg::pmrb_strap_s i_strap,
  input  wire pmrb_pkg::pmrb_event_s i_ev,
  input  wire logic                 i_link_up,
  input  wire logic                 i_an_complete,
  // data paths
  input  wire pmrb_pkg::pmrb_nib_s  i_mii_tx,
  input  wire pmrb_pkg::pmrb_nib_s  i_line_rx,
  output pmrb_pkg::pmrb_nib_s       o_mii_rx,
  // configuration to the core
  output logic                      o_core_reset,
  output logic                      o_loopback,
  output pmrb_pkg::pmrb_strap_s     o_mode,
  output logic                      o_power_down
);

  initial begin
    if (P_RESET_CYCLES < 1 || P_RESET_CYCLES >= (1 << `PMRB_TMR_W)) begin
      $error("P_RESET_CYCLES out of range");
    end
  end

  localparam logic [`PMRB_TMR_W-1:0] RST_LAST = `PMRB_TMR_W'(P_RESET_CYCLES - 1);
  localparam logic [31:0]            RW_MASK  = `PMRB_RW_MASK;

  // write mask must match the access map
  initial begin
    if (RW_MASK[`PMRB_A_STAT] || RW_MASK[`PMRB_A_IDH] || RW_MASK[`PMRB_A_IDL]) begin
      $error("read-only offset in write mask");
    end
    if (RW_MASK[`PMRB_A_SUMM] || RW_MASK[`PMRB_A_ISTS]) begin
      $error("status offset in write mask");
    end
    if (RW_MASK[15:8] != 8'h00 || RW_MASK[31:26] != 6'h00) begin
      $error("reserved offset in write mask");
    end
    if (!RW_MASK[`PMRB_A_CTRL]) begin
      $error("control offset missing from write mask");
    end
    if (`PMRB_NREG != 32) begin
      $error("bank must span 32 offsets");
    end
    if (`PMRB_PRE_ONES < 6'h20) begin
      $error("preamble shorter than 32 ones");
    end
  end

  pmrb_pkg::pmrb_state_s r;
  pmrb_pkg::pmrb_state_s next_r;
  pmrb_pkg::pmrb_state_s rst_val;

  // default contents of a register, straps folded into control
  function automatic logic [15:0] def_val(input logic [4:0]           a,
                                          input pmrb_pkg::pmrb_strap_s s);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      `PMRB_A_CTRL: begin
        v[`PMRB_B_SPEED]  = s.speed_100;
        v[`PMRB_B_ANEN]   = s.an_enable;
        v[`PMRB_B_DUPLEX] = s.full_duplex;
      end
      `PMRB_A_ADV:  v = `PMRB_ADV_RST;
      `PMRB_A_ICTL: v = `PMRB_ICTL_RST;
      `PMRB_A_PCS:  v = `PMRB_PCS_RST;
      `PMRB_A_LBK:  v = `PMRB_LBK_RST;
      `PMRB_A_TEN:  v = `PMRB_TEN_RST;
      `PMRB_A_DEVC: v = `PMRB_DEVC_RST;
      default:      v = 16'h0000;
    endcase
    return v;
  endfunction : def_val

  // read view of one address
  function automatic logic [15:0] rd_val(input logic [4:0]           a,
                                         input pmrb_pkg::pmrb_state_s s,
                                         input logic                 an_done);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      `PMRB_A_CTRL: begin
        v = s.rw[`PMRB_A_CTRL];
        v[`PMRB_B_SRST] = s.busy;
      end
      `PMRB_A_STAT: begin
        v = `PMRB_STAT_PERM;
        v[`PMRB_B_ANDONE] = an_done;
        v[`PMRB_B_LINK]   = s.link_lat;
      end
      `PMRB_A_IDH:  v = P_ID_HIGH;
      `PMRB_A_IDL:  v = P_ID_LOW;
      `PMRB_A_SUMM: begin
        v[0] = s.link_lat;
        v[1] = s.rw[`PMRB_A_CTRL][`PMRB_B_DUPLEX];
        v[2] = s.rw[`PMRB_A_CTRL][`PMRB_B_LOOP];
      end
      `PMRB_A_ISTS: begin
        v[0] = s.irq[0];
        v[1] = s.irq[1];
        v[2] = s.irq[2];
        v[3] = s.irq[3];
        v[`PMRB_B_IRQ_ANY] = |(s.irq & s.rw[`PMRB_A_ICTL][3:0]);
      end
      `PMRB_A_ADV, `PMRB_A_LPA, `PMRB_A_EXP, `PMRB_A_NPT: begin
        v = s.rw[a];
      end
      `PMRB_A_ICTL: begin
        v = s.rw[a];
      end
      `PMRB_A_CNT0, `PMRB_A_CNT1, `PMRB_A_CNT2: begin
        v = s.rw[a];
      end
      `PMRB_A_PCS, `PMRB_A_LBK, `PMRB_A_TEN, `PMRB_A_DEVC: begin
        v = s.rw[a];
      end
      default: begin
        v = 16'h0000;
      end
    endcase
    return v;
  endfunction : rd_val

  // frame header addressed to this device with a valid opcode
  function automatic logic hdr_ok(input logic [15:0] h,
                                  input logic [4:0]  pa);
    logic st_ok;
    logic ad_ok;
    logic op_ok;
    st_ok = h[12];
    ad_ok = (h[9:5] == pa);
    op_ok = h[11] ^ h[10];
    return st_ok && ad_ok && op_ok;
  endfunction : hdr_ok

  // default image of the whole bank for given straps
  function automatic logic [`PMRB_NREG-1:0][15:0] bank_dflt(
      input pmrb_pkg::pmrb_strap_s s);
    logic [`PMRB_NREG-1:0][15:0] b;
    b = '0;
    for (int a = 0; a < `PMRB_NREG; a++) begin
      b[a] = def_val(5'(a), s);
    end
    return b;
  endfunction : bank_dflt

  // saturating event counters, one per counted event
  logic [2:0][15:0] cnt_inc;
  logic [3:0]       ev_vec;
  assign ev_vec = {~i_link_up, i_ev.rx_error, i_ev.false_carrier, i_ev.disconnect};
  for (genvar k = 0; k < 3; k++) begin : g_cnt
    logic [15:0] cur;
    assign cur        = r.rw[`PMRB_A_CNT0 + k];
    assign cnt_inc[k] = (ev_vec[k] && cur != 16'hFFFF) ? cur + 16'h0001 : cur;
  end

  // hardware reset image, straps caught here only
  always_comb begin
    rst_val            = '0;
    rst_val.st         = pmrb_pkg::PMRB_PRE;
    rst_val.mdc_q      = 1'b1;
    rst_val.strap      = i_strap;
    rst_val.rw         = bank_dflt(i_strap);
  end

  always_comb begin
    logic        rise;
    logic [15:0] nsh;
    logic [15:0] wd;
    logic        rd_stat;
    logic        rd_ists;
    logic [3:0]  ev_irq;
    next_r  = r;
    rise    = 1'b0;
    nsh     = 16'h0000;
    wd      = 16'h0000;
    rd_stat = 1'b0;
    rd_ists = 1'b0;
    ev_irq  = ev_vec;
    if (i_clk_en) begin
      rise         = i_mdc & ~r.mdc_q;
      next_r.mdc_q = i_mdc;

      // event counters, saturating
      for (int k = 0; k < 3; k++) begin
        next_r.rw[`PMRB_A_CNT0 + k] = cnt_inc[k];
      end

      // management frame engine
      if (rise) begin
        unique case (r.st)
          pmrb_pkg::PMRB_PRE: begin
            if (i_mdio) begin
              if (r.cnt != `PMRB_PRE_ONES) begin
                next_r.cnt = r.cnt + 6'h01;
              end
            end else if (r.cnt == `PMRB_PRE_ONES) begin
              next_r.st  = pmrb_pkg::PMRB_HDR;
              next_r.cnt = 6'h00;
            end else begin
              next_r.cnt = 6'h00;
            end
          end
          pmrb_pkg::PMRB_HDR: begin
            nsh        = {r.sh[14:0], i_mdio};
            next_r.sh  = nsh;
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == 6'h0C) begin
              next_r.cnt   = 6'h00;
              next_r.reg_a = nsh[4:0];
              next_r.op_rd = nsh[11];
              if (hdr_ok(nsh, i_phy_addr)) begin
                next_r.st = pmrb_pkg::PMRB_TA;
                if (nsh[11]) begin
                  next_r.sh = rd_val(nsh[4:0], r, i_an_complete);
                  rd_stat   = (nsh[4:0] == `PMRB_A_STAT);
                  rd_ists   = (nsh[4:0] == `PMRB_A_ISTS);
                end
              end else begin
                next_r.st = pmrb_pkg::PMRB_PRE;
              end
            end
          end
          pmrb_pkg::PMRB_TA: begin
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == 6'h00 && r.op_rd) begin
              next_r.mdio_oe = 1'b1;
              next_r.mdio_o  = 1'b0;
            end
            if (r.cnt == 6'h01) begin
              next_r.cnt = 6'h00;
              if (r.op_rd) begin
                next_r.mdio_o = r.sh[15];
                next_r.sh     = {r.sh[14:0], 1'b0};
                next_r.st     = pmrb_pkg::PMRB_RDATA;
              end else begin
                next_r.st = pmrb_pkg::PMRB_WDATA;
              end
            end
          end
          pmrb_pkg::PMRB_RDATA: begin
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == 6'h0F) begin
              next_r.mdio_oe = 1'b0;
              next_r.mdio_o  = 1'b0;
              next_r.cnt     = 6'h00;
              next_r.st      = pmrb_pkg::PMRB_PRE;
            end else begin
              next_r.mdio_o = r.sh[15];
              next_r.sh     = {r.sh[14:0], 1'b0};
            end
          end
          pmrb_pkg::PMRB_WDATA: begin
            wd         = {r.sh[14:0], i_mdio};
            next_r.sh  = wd;
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == 6'h0F) begin
              next_r.cnt = 6'h00;
              next_r.st  = pmrb_pkg::PMRB_PRE;
              if (RW_MASK[r.reg_a] && !r.busy) begin
                next_r.rw[r.reg_a] = wd;
                if (r.reg_a == `PMRB_A_CTRL) begin
                  next_r.rw[`PMRB_A_CTRL][`PMRB_B_SRST] = 1'b0;
                  if (wd[`PMRB_B_SRST]) begin
                    next_r.busy       = 1'b1;
                    next_r.core_rst   = 1'b1;
                    next_r.start_seen = 1'b0;
                    next_r.tmr        = '0;
                  end
                end
              end
            end
          end
          default: begin
            next_r.st = pmrb_pkg::PMRB_PRE;
          end
        endcase
      end

      // latched status, set wins over clear on read
      if (!i_link_up) begin
        next_r.link_lat = 1'b0;
      end else if (rd_stat) begin
        next_r.link_lat = 1'b1;
      end
      next_r.irq = (rd_ists ? 4'h0 : r.irq) | ev_irq;

      // soft reset sequence
      if (r.busy) begin
        next_r.rw       = bank_dflt(r.strap);
        next_r.irq      = 4'h0;
        next_r.link_lat = 1'b0;
        if (r.core_rst) begin
          next_r.tmr = r.tmr + `PMRB_TMR_W'(1);
          if (r.tmr == RST_LAST) begin
            next_r.core_rst = 1'b0;
          end
        end else if (r.start_seen || i_ev.neg_started || i_ev.forced_mode) begin
          next_r.busy = 1'b0;
        end
        if (!r.core_rst && (i_ev.neg_started || i_ev.forced_mode)) begin
          next_r.start_seen = 1'b1;
        end
      end

      // receive path, looped from transmit when asked
      if (r.rw[`PMRB_A_CTRL][`PMRB_B_LOOP]) begin
        next_r.rx = i_mii_tx;
      end else begin
        next_r.rx = i_line_rx;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r <= rst_val;
    end else begin
      r <= next_r;
    end
  end

  assign o_mdio              = r.mdio_o;
  assign o_mdio_oe           = r.mdio_oe;
  assign o_mii_rx            = r.rx;
  assign o_core_reset        = r.core_rst;
  assign o_loopback          = r.rw[`PMRB_A_CTRL][`PMRB_B_LOOP];
  assign o_mode.speed_100    = r.rw[`PMRB_A_CTRL][`PMRB_B_SPEED];
  assign o_mode.an_enable    = r.rw[`PMRB_A_CTRL][`PMRB_B_ANEN];
  assign o_mode.full_duplex  = r.rw[`PMRB_A_CTRL][`PMRB_B_DUPLEX];
  assign o_power_down        = r.rw[`PMRB_A_CTRL][`PMRB_B_PDOWN];

endmodule : pmrb_bank
`default_nettype wire

// ---- pmrb_host.sv ----
// management host model driving the serial management port
`timescale 1ns/1ns
`default_nettype none
module pmrb_host #(
  parameter logic [4:0] P_PHY = 5'h05
) (
  // clock and shared wire
  input  wire logic i_ref_clk,
  input  wire logic i_line,
  // host drive
  output var logic  o_mdc,
  output var logic  o_drv,
  output var logic  o_drv_en
);
  initial begin
    o_mdc = 1'b0;
    o_drv = 1'b1;
    o_drv_en = 1'b0;
  end
  // one bit per four clocks, mdc still between frames
  task automatic bit_cyc(input logic b, input logic en, output logic s);
    @(posedge i_ref_clk);
    #1;
    o_mdc = 1'b0;
    o_drv = b;
    o_drv_en = en;
    repeat (2) @(posedge i_ref_clk);
    #1;
    s = i_line;
    o_mdc = 1'b1;
    @(posedge i_ref_clk);
  endtask : bit_cyc
  task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rv);
    logic [45:0] hdr;
    logic        s;
    hdr = {32'hFFFF_FFFF, 2'h1, rd ? 2'h2 : 2'h1, P_PHY, ra};
    for (int i = 45; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
    bit_cyc(1'b1, !rd, s);
    bit_cyc(1'b0, !rd, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wd[i], !rd, s);
      rv[i] = s;
    end
    @(posedge i_ref_clk);
    #1;
    o_mdc = 1'b0;
    o_drv_en = 1'b0;
  endtask : xfer
endmodule : pmrb_host
`default_nettype wire

// ---- pmrb_bank_chk.sv ----
// assertions on the register bank ports
`timescale 1ns/1ns
`default_nettype none
module pmrb_bank_chk #(
  parameter int unsigned P_RESET_CYCLES = 120000
) (
  // clock, reset, inputs
  input wire logic                  i_ref_clk,
  input wire logic                  i_rst,
  input wire logic                  i_mdc,
  input wire pmrb_pkg::pmrb_strap_s i_strap,
  input wire pmrb_pkg::pmrb_nib_s   i_mii_tx,
  input wire pmrb_pkg::pmrb_nib_s   i_line_rx,
  // outputs watched
  input wire logic                  o_mdio,
  input wire logic                  o_mdio_oe,
  input wire pmrb_pkg::pmrb_nib_s   o_mii_rx,
  input wire logic                  o_core_reset,
  input wire logic                  o_loopback,
  input wire pmrb_pkg::pmrb_strap_s o_mode,
  input wire logic                  o_power_down
);
  logic                  mdc_q;
  logic                  rise;
  logic [31:0]           cnt;
  pmrb_pkg::pmrb_strap_s strap_q;
  assign rise = i_mdc & ~mdc_q;
  always_ff @(posedge i_ref_clk) begin
    mdc_q <= i_mdc;
    cnt <= (i_rst || !o_core_reset) ? 32'h0 : cnt + 32'h1;
    if (i_rst) strap_q <= i_strap;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  AST_RST_OUTS: assert property ($fell(i_rst) |-> !o_mdio_oe && !o_core_reset)
    else $error("outputs busy after reset");
  AST_RST_MODE: assert property ($fell(i_rst) |-> o_mode == $past(i_strap) && !o_loopback)
    else $error("mode not from straps after reset");
  AST_LOOP_PATH: assert property (o_loopback && $stable(o_loopback) |=> o_mii_rx == $past(i_mii_tx))
    else $error("loopback path wrong");
  AST_LINE_PATH: assert property (!o_loopback && $stable(o_loopback) |=> o_mii_rx == $past(i_line_rx))
    else $error("line path wrong");
  AST_SRST_LEN: assert property ($fell(o_core_reset) |-> cnt == P_RESET_CYCLES)
    else $error("soft reset length wrong");
  AST_SRST_DFLT: assert property (o_core_reset [*2] |-> !o_loopback && !o_power_down)
    else $error("control not default in soft reset");
  AST_STRAP_KEEP: assert property (o_core_reset [*2] |-> o_mode == strap_q)
    else $error("strap lost in soft reset");
  AST_MDIO_TIMING: assert property (!rise && !$past(rise) |=> $stable(o_mdio) && $stable(o_mdio_oe))
    else $error("management output moved without mdc edge");
endmodule : pmrb_bank_chk
bind pmrb_bank pmrb_bank_chk #(.P_RESET_CYCLES(P_RESET_CYCLES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mdc(i_mdc), .i_strap(i_strap),
  .i_mii_tx(i_mii_tx), .i_line_rx(i_line_rx), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
  .o_mii_rx(o_mii_rx), .o_core_reset(o_core_reset), .o_loopback(o_loopback),
  .o_mode(o_mode), .o_power_down(o_power_down));
`default_nettype wire

// ---- phy_management_register_bank_tb.sv ----
// self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
module phy_management_register_bank_tb;
  localparam logic [15:0] ID_H = 16'hC3A1; // arbitrary value
  localparam logic [15:0] ID_L = 16'h4E72; // arbitrary value
  typedef struct packed {logic [4:0] a; logic [15:0] w, m, e;} pmrb_row_s;
  localparam pmrb_row_s ROWS [0:16] = '{
    '{5'h04, 16'hA5A5, 16'hFFFF, 16'hA5A5}, '{5'h05, 16'h5A5A, 16'hFFFF, 16'h5A5A},
    '{5'h06, 16'h0F0F, 16'hFFFF, 16'h0F0F}, '{5'h07, 16'hF0F0, 16'hFFFF, 16'hF0F0},
    '{5'h11, 16'h000F, 16'hFFFF, 16'h000F}, '{5'h13, 16'h1111, 16'hFFFF, 16'h1111},
    '{5'h14, 16'h2222, 16'hFFFF, 16'h2222}, '{5'h15, 16'h3333, 16'hFFFF, 16'h3333},
    '{5'h16, 16'h4444, 16'hFFFF, 16'h4444}, '{5'h02, 16'hFFFF, 16'hFFFF, ID_H},
    '{5'h03, 16'hFFFF, 16'hFFFF, ID_L}, '{5'h12, 16'hFFFF, 16'hFFFF, 16'h0000},
    '{5'h01, 16'h0000, 16'hF801, 16'h7801}, '{5'h08, 16'hFFFF, 16'hFFFF, 16'h0000},
    '{5'h0F, 16'hFFFF, 16'hFFFF, 16'h0000}, '{5'h1A, 16'hFFFF, 16'hFFFF, 16'h0000},
    '{5'h1F, 16'hFFFF, 16'hFFFF, 16'h0000}};
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  link = 1'b1;
  logic [4:0]            phy = 5'h05;
  logic                  mdc, drv, drv_en, mdio, mdio_oe, core_rst, loop, pdown;
  wire logic             line;
  pmrb_pkg::pmrb_strap_s strap = 3'h5;
  pmrb_pkg::pmrb_strap_s mode;
  pmrb_pkg::pmrb_event_s ev = '0;
  pmrb_pkg::pmrb_nib_s   tx = '0;
  pmrb_pkg::pmrb_nib_s   lrx = '0;
  pmrb_pkg::pmrb_nib_s   rx;
  logic [15:0]           rv;
  int                    miscompares = 0;
  int                    checks_done = 0;
  int                    cycles = 0;
  always #5 clk = ~clk;
  // pull-up when nobody drives
  assign line = mdio_oe ? mdio : (drv_en ? drv : 1'b1);
  pmrb_bank #(.P_RESET_CYCLES(600), .P_ID_HIGH(ID_H), .P_ID_LOW(ID_L)) dut (
    .i_ref_clk(clk), .i_rst(rst), .i_clk_en(1'b1), .i_mdc(mdc), .i_mdio(line),
    .o_mdio(mdio), .o_mdio_oe(mdio_oe), .i_phy_addr(phy), .i_strap(strap), .i_ev(ev),
    .i_link_up(link), .i_an_complete(1'b0), .i_mii_tx(tx), .i_line_rx(lrx),
    .o_mii_rx(rx), .o_core_reset(core_rst), .o_loopback(loop), .o_mode(mode),
    .o_power_down(pdown));
  pmrb_host #(.P_PHY(5'h05)) u_host (.i_ref_clk(clk), .i_line(line), .o_mdc(mdc),
    .o_drv(drv), .o_drv_en(drv_en));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    u_host.xfer(1'b1, a, 16'h0000, v);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    u_host.xfer(1'b0, a, d, v);
  endtask : wr
  task automatic pulse_ev(input pmrb_pkg::pmrb_event_s e);
    @(posedge clk);
    #1;
    ev = e;
    @(posedge clk);
    #1;
    ev = '0;
  endtask : pulse_ev
  task automatic wait_core(input logic lvl);
    for (int i = 0; i < 2000 && core_rst !== lvl; i++) @(posedge clk);
  endtask : wait_core
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].w);
      rd(ROWS[i].a, rv);
      chk("reg row", rv & ROWS[i].m, ROWS[i].e);
    end
    $display("test rows done");
    phy = 5'h06;
    rd(5'h04, rv);
    chk("foreign address", rv, 16'hFFFF);
    phy = 5'h05;
    $display("test address done");
    pulse_ev(5'h04);
    rd(5'h12, rv);
    chk("irq latch", rv, 16'h8004);
    rd(5'h12, rv);
    chk("irq cleared", rv, 16'h0000);
    rd(5'h15, rv);
    chk("rx error count", rv, 16'h3334);
    link = 1'b0;
    @(posedge clk);
    #1;
    link = 1'b1;
    rd(5'h01, rv);
    chk("link latched low", rv & 16'h0004, 16'h0000);
    rd(5'h01, rv);
    chk("link back up", rv & 16'h0004, 16'h0004);
    rd(5'h12, rv);
    chk("link irq", rv, 16'h8008);
    $display("test latch done");
    wr(5'h00, 16'h4000);
    @(posedge clk);
    #1;
    tx = 6'h2B;
    lrx = 6'h14;
    strap = 3'h2;
    repeat (2) @(posedge clk);
    #1;
    chk("loopback", {15'h0, loop}, 16'h0001);
    chk("rx nibble", {10'h000, rx}, 16'h002B);
    $display("test loopback done");
    wr(5'h00, 16'hC000);
    wait_core(1'b1);
    rd(5'h00, rv);
    chk("reset bit busy", rv & 16'h8000, 16'h8000);
    wait_core(1'b0);
    rd(5'h00, rv);
    chk("reset bit held", rv & 16'h8000, 16'h8000);
    pulse_ev(5'h02);
    rd(5'h00, rv);
    chk("reset bit clear", rv & 16'h8000, 16'h0000);
    rd(5'h04, rv);
    chk("adv default", rv, 16'h01E1);
    chk("mode kept", {13'h0, mode}, 16'h0005);
    chk("loop off", {15'h0, loop}, 16'h0000);
    wr(5'h00, 16'h0800);
    @(posedge clk);
    #1;
    chk("power down", {15'h0, pdown}, 16'h0001);
    $display("test soft reset done");
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("mode from straps", {13'h0, mode}, 16'h0002);
    rd(5'h00, rv);
    chk("control after reset", rv, 16'h1000);
    $display("test hw reset done");
    test_done();
  end
endmodule : phy_management_register_bank_tb
`default_nettype wire
